// ===== logic/i2cmm_defines.vh
// constants for the two-wire serial memory master
`ifndef I2CMM_DEFINES_VH
`define I2CMM_DEFINES_VH
`define I2CMM_CLK_HZ        200000000
`define I2CMM_STD_HZ        100000
`define I2CMM_FAST_HZ       400000
`define I2CMM_QDIV_W        10
`define I2CMM_QPB           4
`define I2CMM_DIR_WRITE     1'b0
`define I2CMM_DIR_READ      1'b1
`define I2CMM_ACK           1'b0
`define I2CMM_NACK          1'b1
`define I2CMM_BIT_MSB       3'h7
`define I2CMM_PH_LAST       2'h3
`endif

// ===== logic/i2cmm_master.v
// two-wire serial memory master: start, address, byte address, data bytes, stop
// Contract
// - only 7-bit target addresses are sent, never the 10-bit form.
// - the clock runs at up to 100 kHz in standard speed or up to 400 kHz in fast speed; the rounded-down quarter count can push it above.
// - the clock output works either open-drain or push-pull, chosen by an input.
// - in push-pull the clock line is driven both high and low; data stays open-drain.
// - every transfer opens with a start condition.
// - the 7-bit target address then the 8-bit memory location are sent first.
// - every address and data byte leaves most significant bit first.
// - target address and memory location come from inputs so they fit any memory.
// - on read the block returns an acknowledge bit after each received byte except the last.
// - on write the block samples the memory's acknowledge after each sent byte.
// - a transfer moves one byte or several in a row.
// - the last byte read is answered with a not-acknowledge.
// - a stop condition ends the transfer once all bytes are moved.
// each bit takes four quarters: clock low with data set, clock released,
// data sampled while high, clock pulled low again; start and stop use the
// same four quarters with data moving while the clock is high
`timescale 1ns/1ps
`include "i2cmm_defines.vh"
module i2cmm_master #(
    parameter CLK_HZ = `I2CMM_CLK_HZ
) (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire       fastMode,
    input  wire       pushPull,
    input  wire       startReq,
    input  wire       readReq,
    input  wire [6:0] target_id_bits,
    input  wire [7:0] memory_location_bits,
    input  wire [7:0] byteCount,
    input  wire [7:0] writeData,
    output wire       writeTaken,
    output reg  [7:0] readData,
    output reg        readValid,
    output reg        nackSeen,
    output wire       busy,
    output reg        done,
    input  wire       sclIn,
    output wire       sclOut,
    output wire       sclOe,
    input  wire       sdaIn,
    output wire       sdaOut,
    output wire       sdaOe
);
    // quarter bit period counts; integer division rounds down so the clock can run above the limit
    // the counter is 10 bits wide: a faster system clock needs a wider counter
    localparam integer Q_STD_N  = CLK_HZ / (`I2CMM_QPB * `I2CMM_STD_HZ);
    localparam integer Q_FAST_N = CLK_HZ / (`I2CMM_QPB * `I2CMM_FAST_HZ);
    localparam [`I2CMM_QDIV_W-1:0] Q_STD  = Q_STD_N[`I2CMM_QDIV_W-1:0];
    localparam [`I2CMM_QDIV_W-1:0] Q_FAST = Q_FAST_N[`I2CMM_QDIV_W-1:0];

    localparam [8:0] S_IDLE  = 9'h001;
    localparam [8:0] S_START = 9'h002;
    localparam [8:0] S_ADDR  = 9'h004;
    localparam [8:0] S_LOC   = 9'h008;
    localparam [8:0] S_RSTRT = 9'h010;
    localparam [8:0] S_RADDR = 9'h020;
    localparam [8:0] S_WDATA = 9'h040;
    localparam [8:0] S_RDATA = 9'h080;
    localparam [8:0] S_STOP  = 9'h100;

    reg [8:0] state;
    reg [`I2CMM_QDIV_W-1:0] qCnt;
    reg [1:0] phase;
    reg [3:0] bitIdx;
    reg [7:0] shiftReg;
    reg [7:0] remain;
    reg       isRead;
    reg       sclLow;
    reg       sdaLow;
    reg       sdaS1;
    reg       sdaS2;
    reg       sclS1;
    reg       sclS2;
    reg       takePulse;

    wire qZero   = (qCnt == {`I2CMM_QDIV_W{1'b0}});
    // a memory may stretch the clock: wait in the high quarter until the line reads high
    wire sclHeld = qZero && (phase == 2'h2) && !sclLow && !sclS2 && (state != S_IDLE);
    wire tick    = qZero && !sclHeld;
    wire lastPh  = (phase == `I2CMM_PH_LAST);
    wire ackBit  = (bitIdx == 4'h8);
    reg  [8:0] seqByte;

    // address byte: 7-bit target then direction, never the 10-bit form
    always @* begin
        if (state == S_RADDR) begin
            seqByte = {target_id_bits, `I2CMM_DIR_READ, 1'b0};
        end else begin
            seqByte = {target_id_bits, `I2CMM_DIR_WRITE, 1'b0};
        end
    end

    assign busy       = (state != S_IDLE);
    assign writeTaken = takePulse;
    // open-drain: only pull low; push-pull clock drives both levels
    assign sclOut = ~sclLow;
    assign sclOe  = sclLow | (pushPull & busy);
    assign sdaOut = 1'b0;
    assign sdaOe  = sdaLow;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdaS1 <= 1'b1;
            sdaS2 <= 1'b1;
            sclS1 <= 1'b1;
            sclS2 <= 1'b1;
        end else begin
            sdaS1 <= sdaIn;
            sdaS2 <= sdaS1;
            sclS1 <= sclIn;
            sclS2 <= sclS1;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            qCnt <= {`I2CMM_QDIV_W{1'b0}};
        end else if (tick || state == S_IDLE) begin
            qCnt <= fastMode ? Q_FAST - 1'b1 : Q_STD - 1'b1;
        end else if (sclHeld) begin
            qCnt <= qCnt;
        end else begin
            qCnt <= qCnt - 1'b1;
        end
    end

    // each bit spends four quarters: low/setup, low, high, high
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= S_IDLE;
            phase     <= 2'h0;
            bitIdx    <= 4'h0;
            shiftReg  <= 8'h00;
            remain    <= 8'h00;
            isRead    <= 1'b0;
            sclLow    <= 1'b0;
            sdaLow    <= 1'b0;
            readData  <= 8'h00;
            readValid <= 1'b0;
            nackSeen  <= 1'b0;
            done      <= 1'b0;
            takePulse <= 1'b0;
        end else begin
            readValid <= 1'b0;
            done      <= 1'b0;
            takePulse <= 1'b0;
            if (tick && state != S_IDLE) begin
                phase <= phase + 2'h1;
            end
            case (state)
                S_IDLE: begin
                    sclLow <= 1'b0;
                    sdaLow <= 1'b0;
                    phase  <= 2'h0;
                    if (startReq) begin
                        isRead   <= readReq;
                        if (byteCount == 8'h00) begin
                            remain <= 8'h01;
                        end else begin
                            remain <= byteCount;
                        end
                        nackSeen <= 1'b0;
                        state    <= S_START;
                    end
                end
                S_START, S_RSTRT: begin
                    // data falls while clock high, then clock falls
                    if (tick) begin
                        case (phase)
                            2'h0: begin
                                sdaLow <= 1'b0;
                            end
                            2'h1: begin
                                sclLow <= 1'b0;
                            end
                            2'h2: begin
                                sdaLow <= 1'b1;
                            end
                            default: begin
                                sclLow <= 1'b1;
                                bitIdx <= 4'h0;
                                if (state == S_START) begin
                                    state <= S_ADDR;
                                end else begin
                                    state <= S_RADDR;
                                end
                            end
                        endcase
                    end
                end
                S_ADDR, S_LOC, S_RADDR, S_WDATA, S_RDATA: begin
                    if (tick) begin
                        case (phase)
                            2'h0: begin
                                sclLow <= 1'b1;
                                if (state == S_RDATA) begin
                                    // ack on all but the final byte
                                    sdaLow <= ackBit && (remain != 8'h01);
                                end else if (ackBit) begin
                                    sdaLow <= 1'b0;
                                end else if (bitIdx == 4'h0) begin
                                    if (state == S_WDATA) begin
                                        shiftReg  <= {writeData[6:0], 1'b0};
                                        sdaLow    <= ~writeData[`I2CMM_BIT_MSB];
                                        takePulse <= 1'b1;
                                    end else if (state == S_LOC) begin
                                        shiftReg <= {memory_location_bits[6:0], 1'b0};
                                        sdaLow   <= ~memory_location_bits[`I2CMM_BIT_MSB];
                                    end else begin
                                        shiftReg <= seqByte[7:0];
                                        sdaLow   <= ~seqByte[8];
                                    end
                                end else begin
                                    sdaLow   <= ~shiftReg[`I2CMM_BIT_MSB];
                                    shiftReg <= {shiftReg[6:0], 1'b0};
                                end
                            end
                            2'h1: begin
                                sclLow <= 1'b0;
                            end
                            2'h2: begin
                                if (state == S_RDATA && !ackBit) begin
                                    shiftReg <= {shiftReg[6:0], sdaS2};
                                end
                                if (state != S_RDATA && ackBit && sdaS2) begin
                                    nackSeen <= 1'b1;
                                end
                            end
                            default: begin
                                sclLow <= 1'b1;
                                if (ackBit) begin
                                    bitIdx <= 4'h0;
                                end else begin
                                    bitIdx <= bitIdx + 4'h1;
                                end
                                if (ackBit) begin
                                    if (state == S_RDATA) begin
                                        readData  <= shiftReg;
                                        readValid <= 1'b1;
                                    end
                                    // a refused address or byte ends the transfer early
                                    if (state != S_RDATA && nackSeen) begin
                                        state <= S_STOP;
                                    end else if (state == S_ADDR) begin
                                        state <= S_LOC;
                                    end else if (state == S_LOC) begin
                                        if (isRead) begin
                                            state <= S_RSTRT;
                                        end else begin
                                            state <= S_WDATA;
                                        end
                                    end else if (state == S_RADDR) begin
                                        state <= S_RDATA;
                                    end else begin
                                        remain <= remain - 8'h01;
                                        if (remain == 8'h01) begin
                                            state <= S_STOP;
                                        end
                                    end
                                end
                            end
                        endcase
                    end
                end
                S_STOP: begin
                    // data rises while clock high
                    if (tick) begin
                        case (phase)
                            2'h0: begin
                                sdaLow <= 1'b1;
                            end
                            2'h1: begin
                                sclLow <= 1'b0;
                            end
                            2'h2: begin
                                sdaLow <= 1'b0;
                            end
                            default: begin
                                done  <= 1'b1;
                                state <= S_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== testbench/i2cmm_checker.sv
// port assertions for the serial memory master
`timescale 1ns/1ps
module i2cmm_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pushPull,
    input wire logic startReq,
    input wire logic busy,
    input wire logic done,
    input wire logic readValid,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaOut,
    input wire logic sdaOe
);
    wire sclHigh = !(sclOe && !sclOut);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_reset_release: assert property (disable iff (1'b0) !rst_n |-> !sdaOe && !sclOe)
        else $error("lines driven in reset");
    a_sda_open_drain: assert property (sdaOe |-> !sdaOut)
        else $error("sda driven high");
    a_od_scl_low: assert property (!pushPull && sclOe |-> !sclOut)
        else $error("scl driven high in open drain");
    a_pp_scl_drive: assert property (busy && pushPull |-> sclOe)
        else $error("scl not driven in push pull");
    a_start_first: assert property ($rose(busy) |-> ##[1:100] ($rose(sdaOe) && sclHigh))
        else $error("no start condition");
    a_take_busy: assert property (startReq && !busy && !done |=> busy)
        else $error("request not taken");
    a_stop_release: assert property (done |-> !sdaOe && sclHigh ##1 !done)
        else $error("bus not released at done");
    a_read_pulse: assert property (readValid |=> !readValid)
        else $error("read strobe too long");
endmodule

bind i2cmm_master i2cmm_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .pushPull(pushPull),
    .startReq(startReq), .busy(busy), .done(done), .readValid(readValid), .sclOut(sclOut),
    .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));

// ===== testbench/i2cmm_master_tb.sv
// self-checking bench for the serial memory master
`timescale 1ns/1ps
module i2cmm_master_tb;
    reg        sys_clk = 1'b0;
    reg        rst_n = 1'b1;
    reg        fastMode = 1'b0;
    reg        pushPull = 1'b0;
    reg        startReq = 1'b0;
    reg        readReq = 1'b0;
    reg  [6:0] targetId = 7'h50;
    reg  [7:0] location = 8'h00;
    reg  [7:0] byteCount = 8'h01;
    reg  [7:0] writeData = 8'h00;
    reg  [7:0] pat [0:2];
    reg  [7:0] got [0:2];
    wire [7:0] readData;
    wire       writeTaken, readValid, nackSeen, busy, done, sclOut, sclOe, sdaOut, sdaOe, sdaLow;
    wire       scl = !(sclOe && !sclOut);
    wire       sda = !((sdaOe && !sdaOut) || sdaLow);
    integer    nMismatch = 0;
    integer    testsRun = 0;
    integer    nRd;
    initial forever #2.5 sys_clk = !sys_clk;
    // a lower clock figure keeps each quarter short: 20 cycles standard, 5 fast
    i2cmm_master #(.CLK_HZ(8000000)) i_i2cmm_master (.sys_clk(sys_clk), .rst_n(rst_n),
        .fastMode(fastMode), .pushPull(pushPull), .startReq(startReq), .readReq(readReq),
        .target_id_bits(targetId), .memory_location_bits(location), .byteCount(byteCount),
        .writeData(writeData), .writeTaken(writeTaken), .readData(readData),
        .readValid(readValid), .nackSeen(nackSeen), .busy(busy), .done(done), .sclIn(scl),
        .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
    i2cmm_mem_model #(.ID(7'h50)) i_i2cmm_mem_model (.scl(scl), .sda(sda), .sdaLow(sdaLow));
    task check(input string what, input [7:0] exp, input [7:0] seen);
        begin
            testsRun = testsRun + 1;
            if (seen !== exp) begin
                nMismatch = nMismatch + 1;
                $display("wrong value %s: expected %h, seen %h", what, exp, seen);
            end
        end
    endtask
    task xfer(input rd, input [6:0] id, input [7:0] loc, input [7:0] cnt);
        integer nWr;
        begin
            nWr = 1;
            nRd = 0;
            @(posedge sys_clk);
            readReq <= rd;
            targetId <= id;
            location <= loc;
            byteCount <= cnt;
            writeData <= pat[0];
            startReq <= 1'b1;
            @(posedge sys_clk);
            startReq <= 1'b0;
            while (done !== 1'b1) begin
                @(posedge sys_clk);
                if (writeTaken === 1'b1 && nWr < 3) begin
                    writeData <= pat[nWr];
                    nWr = nWr + 1;
                end
                if (readValid === 1'b1 && nRd < 3) begin
                    got[nRd] = readData;
                    nRd = nRd + 1;
                end
            end
        end
    endtask
    task t_write;
        integer i;
        begin
            fastMode <= 1'b1;
            pushPull <= 1'b1;
            xfer(1'b0, 7'h50, 8'hF0, 8'h03);
            for (i = 0; i < 3; i = i + 1)
                check("memory byte", pat[i], i_i2cmm_mem_model.mem[8'hF0 + i]);
            check("nack flag", 8'h00, {7'h00, nackSeen});
        end
    endtask
    task t_read;
        integer i;
        begin
            fastMode <= 1'b0;
            pushPull <= 1'b0;
            xfer(1'b1, 7'h50, 8'hF0, 8'h03);
            check("read count", 8'h03, nRd[7:0]);
            for (i = 0; i < 3; i = i + 1)
                check("read byte", pat[i], got[i]);
            check("master acks", 8'h01, {5'h00, i_i2cmm_mem_model.ackLog[2:0]});
        end
    endtask
    task t_nack;
        begin
            xfer(1'b0, 7'h51, 8'h00, 8'h01);
            check("nack flag", 8'h01, {7'h00, nackSeen});
        end
    endtask
    task results;
        begin
            $display("checks %0d, mismatches %0d", testsRun, nMismatch);
            if (nMismatch == 0 && testsRun > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        nMismatch = nMismatch + 1;
        results;
    end
    initial begin
        pat[0] = 8'hA5;
        pat[1] = 8'h3C;
        pat[2] = 8'h81;
        #1 rst_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_write;
        t_read;
        t_nack;
        results;
    end
endmodule

// ===== testbench/i2cmm_mem_model.sv
// behavioural serial memory on the far side of the two-wire bus
`timescale 1ns/1ps
module i2cmm_mem_model #(
    parameter [6:0] ID = 7'h50
) (
    input  wire scl,
    input  wire sda,
    output reg  sdaLow = 1'b0
);
    reg [7:0] mem [0:255];
    reg [7:0] sh;
    reg [7:0] ptr = 8'h00;
    reg [7:0] ackLog = 8'h00;
    reg [3:0] bitNo = 4'h0;
    reg [3:0] ph = 4'h0;
    reg       rd = 1'b0;
    reg       sel = 1'b0;
    wire      recv = (ph == 4'h0) || !rd;
    always @(negedge sda) begin
        if (scl) begin
            bitNo = 4'hF;
            ph = 4'h0;
            sdaLow = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (bitNo < 4'h8 && recv)
            sh = {sh[6:0], sda};
        else if (bitNo == 4'h8 && !recv) begin
            ackLog = {ackLog[6:0], sda};
            sel = sel && !sda;
        end
    end
    always @(negedge scl) begin
        bitNo = bitNo + 4'h1;
        if (bitNo == 4'h8) begin
            sdaLow = 1'b0;
            if (recv) begin
                if (ph == 4'h0) begin
                    sel = (sh[7:1] == ID);
                    rd = sh[0];
                end else if (ph == 4'h1 && sel)
                    ptr = sh;
                else if (sel) begin
                    mem[ptr] = sh;
                    ptr = ptr + 8'h01;
                end
                sdaLow = sel;
            end
        end else if (bitNo == 4'h9) begin
            bitNo = 4'h0;
            ph = ph + 4'h1;
            sdaLow = 1'b0;
            if (rd && sel) begin
                sh = mem[ptr];
                ptr = ptr + 8'h01;
            end
        end
        // while selected for reading, drive each data bit of the read byte, most significant first
        if (bitNo < 4'h8 && rd && ph != 4'h0 && sel)
            sdaLow = !sh[3'h7 - bitNo[2:0]];
    end
endmodule
